// >>> verilog/qmc_consts.vh
// Purpose: Constants for the quad mode entry/exit command interpreter
// Assumes: Included by the design files by bare name
// Notes: Offsets are Wishbone byte addresses; opcodes are serial instruction codes
`ifndef QMC_CONSTS_VH
`define QMC_CONSTS_VH

// Serial instruction codes
`define QMC_OP_RD_SR1 8'h05
`define QMC_OP_RD_SR2 8'h35
`define QMC_OP_WR_SR 8'h01
`define QMC_OP_RD_ANY 8'h65
`define QMC_OP_WR_ANY 8'h71
`define QMC_OP_RST_EN 8'h66
`define QMC_OP_RST 8'h99
`define QMC_OP_EN4B 8'hb7
`define QMC_OP_RD_044 8'heb

// Configuration byte address and field positions
`define QMC_CFG_ADDR 32'h00800003
`define QMC_CFG_QPI_BIT 6
`define QMC_QE_BIT 1
`define QMC_MODE_CONT_NIB 4'ha
`define QMC_CTRL_EN_BIT 0

// Reset values
`define QMC_SR1_RST 8'h00
`define QMC_SR2_RST 8'h00
`define QMC_CFG_RST 8'h00
`define QMC_CTRL_RST 8'h01

// Wishbone register offsets
`define QMC_REG_STATE 8'h00
`define QMC_REG_SR1 8'h04
`define QMC_REG_SR2 8'h08
`define QMC_REG_CFG 8'h0c
`define QMC_REG_CTRL 8'h10

// State register field positions
`define QMC_ST_CONT 0
`define QMC_ST_QPI 1
`define QMC_ST_ADDR4 2
`define QMC_ST_QE 3
`define QMC_ST_ARMED 4

// Transaction phases
`define QMC_PH_CMD 3'd0
`define QMC_PH_ADDR 3'd1
`define QMC_PH_MODE 3'd2
`define QMC_PH_WDATA 3'd3
`define QMC_PH_RDATA 3'd4
`define QMC_PH_IDLE 3'd5

`endif

// >>> verilog/qmc_sync.v
// Purpose: Two flip-flop synchroniser for a bus of pin inputs
// Assumes: Inputs are asynchronous to ref_clk_in
// Notes: The first stage feeds only the second stage
`timescale 1ns/1ps
module qmc_sync #(
    parameter W = 6
) (
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // Pins and synchronised copy
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta;
            reg stable;
            // Two stages per bit
            always @(posedge ref_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    meta <= 1'b0;
                    stable <= 1'b0;
                end else begin
                    meta <= async_in[i];
                    stable <= meta;
                end
            end
            assign sync_out[i] = stable;
        end
    endgenerate
endmodule

// >>> verilog/qmc_top.v
// Purpose: Serial flash command interpreter for quad and mode changes
// Assumes: Serial clock well below ref_clk_in / 4; SDR transfers only
// Notes: Array data is not modelled; read data phases are ignored
`timescale 1ns/1ps
`include "qmc_consts.vh"
// Behaviour
// RULE1 - Quad enable flag is status two bit one
// RULE2 - 05h returns status one, 35h status two
// RULE3 - 01h second byte bit one loads flag
// RULE4 - Host sets flag before continuous quad read
// RULE5 - Mode bits Axh enter continuous read
// RULE6 - Mode 00h leaves continuous after read
// RULE7 - Other mode bits leave continuous mode
// RULE8 - 65h/71h at 800003h bit6 enables quad
// RULE9 - Clearing bit6 returns to single line
// RULE10 - Soft reset sequence leaves quad mode
// RULE11 - Reset is 66h then 99h, any width
// RULE12 - B7h enters 4-byte addressing, no enable
// RULE13 - Continuous mode starts with quad address
module qmc_top (
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // Serial link pins
    input wire sclk_in,
    input wire cs_n_in,
    input wire [3:0] dq_in,
    output reg [3:0] dq_out,
    output reg [3:0] dq_oe_out,
    // Mode indications
    output reg cont_mode_out,
    output reg qpi_mode_out,
    output reg addr4_mode_out,
    // Wishbone slave
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out
);
    // Synchronised pins and edge history
    wire [5:0] pins;
    reg sclk_d;
    reg cs_n_d;
    wire sclk_s = pins[5];
    // Select crosses inverted so the synchroniser's reset value is the idle level
    wire cs_n_s = ~pins[4];
    wire [3:0] dq_s = pins[3:0];
    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;
    wire cs_fall = ~cs_n_s & cs_n_d;
    wire cs_rise = cs_n_s & ~cs_n_d;
    // Bus write lands at the edge where the master sees ack high
    wire bus_wr = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out & wb_sel_in[0];

    // Device state
    reg [7:0] sr1;
    reg [7:0] sr2;
    reg [7:0] cfg;
    reg [7:0] ctrl;
    reg armed;
    reg [2:0] ph;
    reg [7:0] cmd;
    reg [7:0] in_sh;
    reg [3:0] bit_cnt;
    reg [2:0] byte_idx;
    reg [31:0] addr;
    reg [7:0] out_sh;
    reg [7:0] out_byte;
    reg [3:0] out_cnt;
    reg mode_seen;
    reg mode_keep;
    reg [7:0] next_byte;
    reg [3:0] next_bit_cnt;
    wire quad_now;
    wire byte_done;
    wire [2:0] addr_last;
    wire quad_lane_enable_flag = sr2[`QMC_QE_BIT];

    // Lanes used by a phase: four in quad instruction mode or past the 0-4-4 opcode
    function lanes_quad;
        input qpi;
        input [2:0] phase;
        input [7:0] opcode;
        begin
            lanes_quad = qpi | ((opcode == `QMC_OP_RD_044) && (phase != `QMC_PH_CMD));
        end
    endfunction

    // Register offset decode for the Wishbone side
    function [31:0] reg_read;
        input [7:0] adr;
        begin
            case (adr)
                `QMC_REG_STATE: reg_read = {27'h0, armed, quad_lane_enable_flag,
                    addr4_mode_out, qpi_mode_out, cont_mode_out};
                `QMC_REG_SR1: reg_read = {24'h0, sr1};
                `QMC_REG_SR2: reg_read = {24'h0, sr2};
                `QMC_REG_CFG: reg_read = {24'h0, cfg};
                `QMC_REG_CTRL: reg_read = {24'h0, ctrl};
                default: reg_read = 32'h0;
            endcase
        end
    endfunction

    qmc_sync #(.W(6)) i_qmc_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .async_in({sclk_in, ~cs_n_in, dq_in}),
        .sync_out(pins)
    );

    assign quad_now = lanes_quad(qpi_mode_out, ph, cmd);
    assign addr_last = addr4_mode_out ? 3'd3 : 3'd2;

    // Next received byte and bit count at a rising serial edge
    always @* begin
        if (quad_now) begin
            next_byte = {in_sh[3:0], dq_s};
            next_bit_cnt = bit_cnt + 4'd4;
        end else begin
            next_byte = {in_sh[6:0], dq_s[0]};
            next_bit_cnt = bit_cnt + 4'd1;
        end
    end
    assign byte_done = next_bit_cnt[3];

    // Edge history; held during a bus write so a serial edge is taken next cycle
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_d <= 1'b0;
            cs_n_d <= 1'b1;
        end else if (!bus_wr) begin
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
        end
    end

    // Serial command decoder and mode state
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sr1 <= `QMC_SR1_RST;
            sr2 <= `QMC_SR2_RST;
            cfg <= `QMC_CFG_RST;
            ctrl <= `QMC_CTRL_RST;
            armed <= 1'b0;
            ph <= `QMC_PH_IDLE;
            cmd <= 8'h00;
            in_sh <= 8'h00;
            bit_cnt <= 4'h0;
            byte_idx <= 3'h0;
            addr <= 32'h0;
            out_byte <= 8'h00;
            mode_seen <= 1'b0;
            mode_keep <= 1'b0;
            cont_mode_out <= 1'b0;
            qpi_mode_out <= 1'b0;
            addr4_mode_out <= 1'b0;
        end else if (bus_wr) begin
            // Bus write takes the cycle; the held edge history defers serial events
            case (wb_adr_in)
                `QMC_REG_SR1: sr1 <= wb_dat_in[7:0];
                `QMC_REG_SR2: sr2 <= wb_dat_in[7:0];
                `QMC_REG_CFG: begin
                    cfg <= wb_dat_in[7:0];
                    qpi_mode_out <= wb_dat_in[`QMC_CFG_QPI_BIT];
                end
                `QMC_REG_CTRL: ctrl <= wb_dat_in[7:0];
                default: ;
            endcase
        end else if (cs_fall) begin
            bit_cnt <= 4'h0;
            byte_idx <= 3'h0;
            mode_seen <= 1'b0;
            if (!ctrl[`QMC_CTRL_EN_BIT]) begin
                ph <= `QMC_PH_IDLE;
            end else if (cont_mode_out) begin
                // RULE13 quad address first
                ph <= `QMC_PH_ADDR;
                cmd <= `QMC_OP_RD_044;
            end else begin
                ph <= `QMC_PH_CMD;
                cmd <= 8'h00;
            end
        end else if (cs_rise) begin
            ph <= `QMC_PH_IDLE;
            // RULE6 exit at end of read
            // RULE7 other bits exit
            if (mode_seen) begin
                cont_mode_out <= mode_keep;
            end
        end else if (!cs_n_s && sclk_rise && ph != `QMC_PH_IDLE && ph != `QMC_PH_RDATA) begin
            in_sh <= next_byte;
            bit_cnt <= byte_done ? 4'h0 : next_bit_cnt;
            if (byte_done) begin
                byte_idx <= byte_idx + 3'd1;
                case (ph)
                    `QMC_PH_CMD: begin
                        cmd <= next_byte;
                        byte_idx <= 3'h0;
                        armed <= 1'b0;
                        ph <= `QMC_PH_IDLE;
                        case (next_byte)
                            // RULE2 status reads
                            `QMC_OP_RD_SR1: begin
                                out_byte <= sr1;
                                ph <= `QMC_PH_RDATA;
                            end
                            `QMC_OP_RD_SR2: begin
                                out_byte <= sr2;
                                ph <= `QMC_PH_RDATA;
                            end
                            `QMC_OP_WR_SR: ph <= `QMC_PH_WDATA;
                            `QMC_OP_RD_ANY: ph <= `QMC_PH_ADDR;
                            `QMC_OP_WR_ANY: ph <= `QMC_PH_ADDR;
                            `QMC_OP_RD_044: ph <= `QMC_PH_ADDR;
                            // RULE11 reset enable
                            `QMC_OP_RST_EN: armed <= 1'b1;
                            `QMC_OP_RST: begin
                                // RULE10 soft reset exit
                                if (armed) begin
                                    qpi_mode_out <= 1'b0;
                                    cont_mode_out <= 1'b0;
                                    addr4_mode_out <= 1'b0;
                                    cfg <= `QMC_CFG_RST;
                                end
                            end
                            // RULE12 enter 4-byte
                            `QMC_OP_EN4B: addr4_mode_out <= 1'b1;
                            default: ;
                        endcase
                    end
                    `QMC_PH_ADDR: begin
                        addr <= {addr[23:0], next_byte};
                        if (byte_idx == addr_last) begin
                            byte_idx <= 3'h0;
                            if (cmd == `QMC_OP_RD_044) begin
                                ph <= `QMC_PH_MODE;
                            end else if (cmd == `QMC_OP_WR_ANY) begin
                                ph <= `QMC_PH_WDATA;
                            end else begin
                                // RULE8 configuration read
                                ph <= `QMC_PH_RDATA;
                                if (({addr[23:0], next_byte} & (addr4_mode_out ?
                                    32'hffffffff : 32'h00ffffff)) == `QMC_CFG_ADDR) begin
                                    out_byte <= cfg;
                                end else begin
                                    out_byte <= 8'hff;
                                end
                            end
                        end
                    end
                    `QMC_PH_MODE: begin
                        // RULE5 mode bits enter
                        // RULE4 flag gates entry
                        mode_seen <= 1'b1;
                        mode_keep <= (next_byte[7:4] == `QMC_MODE_CONT_NIB) &&
                            quad_lane_enable_flag;
                        ph <= `QMC_PH_IDLE;
                    end
                    `QMC_PH_WDATA: begin
                        if (cmd == `QMC_OP_WR_SR) begin
                            if (byte_idx == 3'd0) begin
                                sr1 <= next_byte;
                            end else begin
                                // RULE3 second byte loads
                                // RULE1 flag at bit one
                                sr2 <= next_byte;
                                ph <= `QMC_PH_IDLE;
                            end
                        end else begin
                            ph <= `QMC_PH_IDLE;
                            if ((addr & (addr4_mode_out ? 32'hffffffff : 32'h00ffffff)) ==
                                `QMC_CFG_ADDR) begin
                                // RULE8 volatile enable
                                // RULE9 clear returns single
                                cfg <= next_byte;
                                qpi_mode_out <= next_byte[`QMC_CFG_QPI_BIT];
                            end
                        end
                    end
                    default: ph <= `QMC_PH_IDLE;
                endcase
            end
        end
    end

    // Read data shifter: drives on falling serial edges
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            out_sh <= 8'h00;
            out_cnt <= 4'h0;
            dq_out <= 4'h0;
            dq_oe_out <= 4'h0;
        end else if (cs_n_s || ph != `QMC_PH_RDATA) begin
            out_cnt <= 4'h0;
            dq_oe_out <= 4'h0;
        end else if (sclk_fall && !bus_wr) begin
            if (quad_now) begin
                dq_out <= (out_cnt == 4'h0) ? out_byte[7:4] : out_sh[7:4];
                out_sh <= (out_cnt == 4'h0) ? {out_byte[3:0], 4'h0} : {out_sh[3:0], 4'h0};
                out_cnt <= (out_cnt == 4'h4) ? 4'h0 : out_cnt + 4'd4;
                dq_oe_out <= 4'hf;
            end else begin
                dq_out <= {2'b00, ((out_cnt == 4'h0) ? out_byte[7] : out_sh[7]), 1'b0};
                out_sh <= (out_cnt == 4'h0) ? {out_byte[6:0], 1'b0} : {out_sh[6:0], 1'b0};
                out_cnt <= (out_cnt == 4'h7) ? 4'h0 : out_cnt + 4'd1;
                dq_oe_out <= 4'h2;
            end
        end
    end

    // Wishbone answer: ack one cycle after the request, dropped the next
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0;
        end else begin
            wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
            if (wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in) begin
                wb_dat_out <= reg_read(wb_adr_in);
            end
        end
    end
endmodule

// >>> dv/qmc_checker.sv
// Purpose: Port checker for qmc_top
// Assumes: Bound to qmc_top
// Notes: Bus handshake, pin enables, mode timing
`timescale 1ns/1ps
module qmc_checker (
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_in,
    // Serial link
    input wire cs_n_in,
    input wire [3:0] dq_oe_out,
    // Modes
    input wire cont_mode_out,
    input wire qpi_mode_out,
    input wire addr4_mode_out,
    // Wishbone
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire [31:0] wb_dat_out,
    input wire wb_ack_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // Bus answers exactly one cycle after a request
    ack_after_req_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("no ack after request");
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
    ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without request");
    rdata_upper_a: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
        else $error("upper read bits set");
    // Pin enables: single, quad or off
    oe_legal_a: assert property (dq_oe_out inside {4'h0, 4'h2, 4'hf})
        else $error("bad enable pattern");
    oe_idle_a: assert property (cs_n_in [*6] |-> dq_oe_out == 4'h0)
        else $error("driving while deselected");
    quad_oe_a: assert property (dq_oe_out == 4'hf |-> qpi_mode_out)
        else $error("quad drive outside quad mode");
    // Continuous mode changes only between frames
    cont_enter_a: assert property ($rose(cont_mode_out) |-> cs_n_in)
        else $error("entry inside frame");
    cont_exit_a: assert property ($fell(cont_mode_out) |-> cs_n_in)
        else $error("exit inside frame");
    cover property ($rose(cont_mode_out));
    cover property ($rose(qpi_mode_out));
    cover property ($rose(addr4_mode_out));
endmodule
bind qmc_top qmc_checker i_qmc_checker (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .cs_n_in(cs_n_in), .dq_oe_out(dq_oe_out), .cont_mode_out(cont_mode_out),
    .qpi_mode_out(qpi_mode_out), .addr4_mode_out(addr4_mode_out), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));

// >>> dv/qmc_host.sv
// Purpose: Host link controller model, 800 ns serial clock
// Assumes: Mode 0, clock idle low between frames
// Notes: Released lines toggle so stale data never passes
`timescale 1ns/1ps
module qmc_host (
    // Resolved lines
    input wire [3:0] dq_line_in,
    // Link pins
    output reg sclk_out,
    output reg cs_n_out,
    output reg [3:0] dq_drv_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        dq_drv_out = 4'h5;
    end
    // One link clock
    task tick;
        begin
            #400 sclk_out = 1'b1;
            #400 sclk_out = 1'b0;
        end
    endtask
    task tx(input [7:0] b, input q);
        integer i;
        begin
            if (q) begin
                dq_drv_out = b[7:4];
                tick;
                dq_drv_out = b[3:0];
                tick;
            end else for (i = 7; i >= 0; i = i - 1) begin
                dq_drv_out = {~dq_drv_out[3:1], b[i]};
                tick;
            end
        end
    endtask
    // Sample read data at each rise
    task rx(output [7:0] b, input q);
        integer i;
        begin
            for (i = 0; i < (q ? 2 : 8); i = i + 1) begin
                dq_drv_out = ~dq_drv_out;
                #400 sclk_out = 1'b1;
                b = q ? {b[3:0], dq_line_in} : {b[6:0], dq_line_in[1]};
                #400 sclk_out = 1'b0;
            end
        end
    endtask
    // Frame open, offset from the system clock
    task sel;
        begin
            #437 cs_n_out = 1'b0;
            #400;
        end
    endtask
    task desel;
        begin
            #400 cs_n_out = 1'b1;
            dq_drv_out = ~dq_drv_out;
            #2400;
        end
    endtask
endmodule

// >>> dv/tb_quad_mode_entry_exit_control.sv
// Purpose: Bench for qmc_top over bus and link
// Assumes: Host model drives the link pins
// Notes: Mode outputs checked after selected frames and bus writes
`timescale 1ns/1ps
module tb_quad_mode_entry_exit_control;
    reg ref_clk_in = 1'b0;
    reg rst_in = 1'b1;
    reg wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
    reg [7:0] wb_adr_in = 8'h00;
    reg [3:0] wb_sel_in = 4'h0;
    reg [31:0] wb_dat_in = 32'h0;
    wire sclk, cs_n, cont, qpi, addr4, wb_ack_out;
    wire [3:0] dq_drv, dq_out, dq_oe, dq_w;
    wire [31:0] wb_dat_out;
    reg [31:0] v;
    reg [7:0] b;
    integer num_errors = 0, tests_run = 0;
    // Line level: device wins where it drives
    assign dq_w = (dq_oe & dq_out) | (~dq_oe & dq_drv);
    initial begin
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    qmc_top i_qmc_top (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .sclk_in(sclk),
        .cs_n_in(cs_n), .dq_in(dq_w), .dq_out(dq_out), .dq_oe_out(dq_oe),
        .cont_mode_out(cont), .qpi_mode_out(qpi), .addr4_mode_out(addr4),
        .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));
    qmc_host i_qmc_host (.dq_line_in(dq_w), .sclk_out(sclk), .cs_n_out(cs_n),
        .dq_drv_out(dq_drv));
    task end_of_test;
        begin
            if (num_errors == 0 && tests_run > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input string name, input [31:0] exp, input [31:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    // Classic single bus cycle, bounded wait for ack
    task wb(input we, input [7:0] a, input [3:0] s, input [31:0] d, output [31:0] q);
        integer n;
        begin
            @(posedge ref_clk_in);
            wb_cyc_in <= 1'b1;
            wb_stb_in <= 1'b1;
            wb_we_in <= we;
            wb_adr_in <= a;
            wb_sel_in <= s;
            wb_dat_in <= d;
            n = 0;
            @(posedge ref_clk_in);
            while (wb_ack_out !== 1'b1 && n < 20) begin
                @(posedge ref_clk_in);
                n = n + 1;
            end
            q = wb_dat_out;
            wb_cyc_in <= 1'b0;
            wb_stb_in <= 1'b0;
            if (n == 20) begin
                chk("bus ack", 1, 0);
                end_of_test;
            end
        end
    endtask
    // Instruction then n bytes of d, top byte first
    task sw(input q, input [7:0] op, input integer n, input [31:0] d);
        integer i;
        begin
            i_qmc_host.sel;
            i_qmc_host.tx(op, q);
            for (i = n - 1; i >= 0; i = i - 1)
                i_qmc_host.tx(d[8*i +: 8], q);
            i_qmc_host.desel;
        end
    endtask
    // Read a status or config byte over the link
    task srd(input [7:0] op, input q, input a4, input string name, input [7:0] exp);
        begin
            i_qmc_host.sel;
            i_qmc_host.tx(op, q);
            if (op == 8'h65) begin
                if (a4)
                    i_qmc_host.tx(8'h00, q);
                i_qmc_host.tx(8'h80, q);
                i_qmc_host.tx(8'h00, q);
                i_qmc_host.tx(8'h03, q);
            end
            i_qmc_host.rx(b, q);
            i_qmc_host.desel;
            chk(name, {24'h0, exp}, {24'h0, b});
        end
    endtask
    // Quad read frame, instruction only when first
    task cr(input first, input [7:0] m);
        integer i;
        begin
            i_qmc_host.sel;
            if (first)
                i_qmc_host.tx(8'heb, 1'b0);
            for (i = 0; i < 3; i = i + 1)
                i_qmc_host.tx(8'h5a, 1'b1);
            i_qmc_host.tx(m, 1'b1);
            i_qmc_host.desel;
        end
    endtask
    initial begin
        repeat (10) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        wb(0, 8'h00, 4'hf, 0, v);
        chk("state", 0, v);
        wb(0, 8'h10, 4'hf, 0, v);
        chk("ctrl", 1, v);
        wb(1, 8'h04, 4'hf, 32'h5c, v);
        wb(1, 8'h04, 4'h0, 32'h11, v);
        wb(0, 8'h04, 4'hf, 0, v);
        chk("sr1 bus", 32'h5c, v);
        wb(1, 8'h40, 4'hf, 32'hff, v);
        wb(0, 8'h40, 4'hf, 0, v);
        chk("unmapped", 0, v);
        wb(1, 8'h0c, 4'hf, 32'h40, v);
        @(posedge ref_clk_in);
        chk("qpi bus", 1, {31'h0, qpi});
        wb(1, 8'h0c, 4'hf, 32'h00, v);
        @(posedge ref_clk_in);
        chk("qpi bus off", 0, {31'h0, qpi});
        sw(0, 8'h01, 2, 32'h5c02);
        srd(8'h05, 0, 0, "sr1 link", 8'h5c);
        srd(8'h35, 0, 0, "sr2 link", 8'h02);
        wb(0, 8'h00, 4'hf, 0, v);
        chk("state flag", 32'h08, v);
        sw(0, 8'h01, 2, 32'h5c00);
        srd(8'h35, 0, 0, "sr2 clear", 8'h00);
        cr(1, 8'ha5);
        chk("cont no flag", 0, {31'h0, cont});
        sw(0, 8'h01, 2, 32'h5c02);
        cr(1, 8'ha5);
        chk("cont enter", 1, {31'h0, cont});
        cr(0, 8'ha0);
        chk("cont stay", 1, {31'h0, cont});
        cr(0, 8'h00);
        chk("cont exit 00", 0, {31'h0, cont});
        srd(8'h05, 0, 0, "sr1 after exit", 8'h5c);
        cr(1, 8'ha5);
        cr(0, 8'h5a);
        chk("cont exit other", 0, {31'h0, cont});
        srd(8'h65, 0, 0, "cfg single", 8'h00);
        sw(0, 8'h71, 4, 32'h80000340);
        chk("qpi on", 1, {31'h0, qpi});
        srd(8'h65, 1, 0, "cfg quad", 8'h40);
        sw(1, 8'h71, 4, 32'h80000300);
        chk("qpi off", 0, {31'h0, qpi});
        srd(8'h05, 0, 0, "sr1 single", 8'h5c);
        sw(0, 8'h71, 4, 32'h80000340);
        sw(1, 8'h99, 0, 0);
        chk("lone reset", 1, {31'h0, qpi});
        sw(1, 8'h66, 0, 0);
        wb(0, 8'h00, 4'hf, 0, v);
        chk("state armed", 32'h1a, v);
        sw(1, 8'h99, 0, 0);
        chk("qpi reset", 0, {31'h0, qpi});
        sw(0, 8'hb7, 0, 0);
        chk("addr4 on", 1, {31'h0, addr4});
        srd(8'h65, 0, 1, "cfg 4 byte", 8'h00);
        sw(0, 8'h66, 0, 0);
        sw(0, 8'h99, 0, 0);
        chk("addr4 reset", 0, {31'h0, addr4});
        wb(1, 8'h10, 4'hf, 32'h0, v);
        sw(0, 8'hb7, 0, 0);
        chk("addr4 gated", 0, {31'h0, addr4});
        wb(1, 8'h10, 4'hf, 32'h1, v);
        sw(0, 8'hb7, 0, 0);
        chk("addr4 again", 1, {31'h0, addr4});
        end_of_test;
    end
endmodule
